// *** hw/cpwc_pkg.sv ***
package cpwc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned FLASH_WAKE_NS = 100_000;
  localparam int unsigned FLASH_WAKE_CYC = (FLASH_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_IRC_CYC = 4;
  localparam int unsigned WAKE_OSC_CYC = 4096;
  localparam int unsigned WCNT_W = 13;
  localparam int unsigned FCNT_W = 11;
  localparam logic [WCNT_W-1:0] WAKE_IRC_LOAD = WCNT_W'(WAKE_IRC_CYC - 1);
  localparam logic [WCNT_W-1:0] WAKE_OSC_LOAD = WCNT_W'(WAKE_OSC_CYC - 1);
  localparam logic [FCNT_W-1:0] FLASH_LOAD = FCNT_W'(FLASH_WAKE_CYC);

  localparam int unsigned PREDIV_W = 8;
  localparam int unsigned MUL_W = 15;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PLLCFG = 8'h04;
  localparam logic [7:0] OFS_CPUDIV = 8'h08;
  localparam logic [7:0] OFS_USBDIV = 8'h0C;
  localparam logic [7:0] OFS_PCONP = 8'h10;
  localparam logic [7:0] OFS_PCLKSEL = 8'h14;
  localparam logic [7:0] OFS_PCON = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  localparam int unsigned CTRL_SRC_LSB = 0;
  localparam int unsigned CTRL_PLLEN = 2;
  localparam int unsigned CTRL_PLLCON = 3;
  localparam int unsigned CTRL_OSCEN = 4;
  localparam int unsigned PLLCFG_N_LSB = 0;
  localparam int unsigned PLLCFG_M_LSB = 8;
  localparam int unsigned ST_LOCK = 0;
  localparam int unsigned ST_CONN = 1;
  localparam int unsigned ST_SRC_LSB = 2;
  localparam int unsigned ST_OSCRDY = 4;
  localparam int unsigned ST_FLASHRDY = 5;
  localparam int unsigned ST_HALT = 6;
  localparam int unsigned ST_STATE_LSB = 8;

  localparam int unsigned SY_MAIN = 0;
  localparam int unsigned SY_IRC = 1;
  localparam int unsigned SY_RTC = 2;
  localparam int unsigned SY_LOCK = 3;
  localparam int unsigned SY_WAKE = 4;

  localparam logic [7:0] CPUDIV_RST = 8'h00;
  localparam logic [7:0] USBDIV_RST = 8'h00;
  localparam logic [31:0] PCONP_RST = 32'hFFFFFFFF;
  localparam logic [31:0] PCLKSEL_RST = 32'h00000000;

  typedef enum logic [1:0] {CPWC_SRC_IRC, CPWC_SRC_MAIN, CPWC_SRC_RTC} cpwc_src_t;
  typedef enum logic [2:0] {CPWC_MODE_NONE, CPWC_MODE_IDLE, CPWC_MODE_SLEEP, CPWC_MODE_PDOWN,
                            CPWC_MODE_DPDOWN} cpwc_mode_t;
  typedef enum logic [2:0] {CPWC_ST_RUN, CPWC_ST_IDLE, CPWC_ST_SLEEP, CPWC_ST_PDOWN, CPWC_ST_DPDOWN,
                            CPWC_ST_IRCUP, CPWC_ST_WAKE} cpwc_state_t;

  typedef struct packed {
    logic enable;
    logic connect;
    logic [PREDIV_W-1:0] preDiv;
    logic [MUL_W-1:0] mul;
  } cpwc_pll_cfg_t;

endpackage : cpwc_pkg

// *** hw/cpwc_divider.sv ***
`timescale 1ns/1ps
module cpwc_divider #(
  parameter int unsigned W = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [W-1:0] div,
  output logic tick
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  // One tick every div+1 cycles while run is high
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt >= div) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_div_stopped;
    !run |=> !tick;
  endproperty
  a_div_stopped: assert property (p_div_stopped) else $error("divider ticked while stopped");

  property p_div_one;
    (run && div == '0 && tick) ##0 (run && $stable(div)) [*2] |-> tick;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

endmodule : cpwc_divider

// *** hw/cpwc_top.sv ***
// Functional notes
// - Reset selects internal RC oscillator; held until software picks another source.
// - Software selects PLL input among internal RC, main and RTC oscillators.
// - PLL input pre-divider N programmable from 1 to 256.
// - Feedback divider M programmable from 1 to 32768 steers the oscillator.
// - Reset and Power-down disable and bypass the PLL.
// - PLL enabled by software only; connect takes effect only once locked.
// - CPU clock equals PLL input unless PLL is enabled and connected.
// - PLL output divided down for both CPU clock and USB clock.
// - Wake from Power-down or Deep power-down runs from internal RC.
// - Wake-up timer blocks execution until oscillator is safe, at reset and Sleep or Power-down wakes.
// - Four software-selected power modes: Idle, Sleep, Power-down, Deep power-down.
// - CPU clock divider sits after source and PLL selection.
// - Each peripheral clock can be gated off individually.
// - Each peripheral has its own independently selectable clock divider.
// - Sleep entry turns off and disconnects PLL, clears CPU and USB dividers.
// - Sleep wake resumes after 4 cycles on RC, 4096 on main oscillator.
// - After Power-down wake, flash counter covers flash start-up before access.
`timescale 1ns/1ps
module cpwc_top #(
  parameter int unsigned NPERIPH = 8,
  parameter int unsigned CPUDIV_W = 8,
  parameter int unsigned USBDIV_W = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mainOscReady,
  input wire logic ircReady,
  input wire logic rtcOscReady,
  input wire logic pllLock,
  input wire logic wakeEvent,
  output cpwc_pkg::cpwc_src_t srcSel,
  output logic ircEnable,
  output logic mainOscEnable,
  output cpwc_pkg::cpwc_pll_cfg_t pllCfg,
  output logic cpuClkEn,
  output logic usbClkEn,
  output logic [NPERIPH-1:0] periphClkEn,
  output logic cpuHalt,
  output logic flashReady
);

  function automatic logic [2:0] pclkDiv(input logic [1:0] sel);
    pclkDiv = 3'((4'h1 << sel) - 4'h1);
  endfunction : pclkDiv

  // Pin synchronisers
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
    end else begin
      syncA <= {wakeEvent, pllLock, rtcOscReady, ircReady, mainOscReady};
      syncB <= syncA;
    end
  end
  logic mainS;
  logic ircS;
  logic rtcS;
  logic lockS;
  logic wakeS;
  assign mainS = syncB[cpwc_pkg::SY_MAIN];
  assign ircS = syncB[cpwc_pkg::SY_IRC];
  assign rtcS = syncB[cpwc_pkg::SY_RTC];
  assign lockS = syncB[cpwc_pkg::SY_LOCK];
  assign wakeS = syncB[cpwc_pkg::SY_WAKE];

  cpwc_pkg::cpwc_state_t state;
  cpwc_pkg::cpwc_state_t next_state;

  // AHB-Lite slave, zero wait states
  logic wrQ;
  logic [7:0] addrQ;
  logic next_wrQ;
  logic [7:0] next_addrQ;
  logic [31:0] next_hrdata;
  logic [31:0] rdVal;
  logic addrPhase;

  cpwc_pkg::cpwc_src_t srcReq;
  cpwc_pkg::cpwc_src_t next_srcReq;
  cpwc_pkg::cpwc_src_t next_srcSel;
  cpwc_pkg::cpwc_pll_cfg_t next_pllCfg;
  cpwc_pkg::cpwc_mode_t modeCmd;
  cpwc_pkg::cpwc_mode_t next_modeCmd;
  logic conReq;
  logic next_conReq;
  logic oscEn;
  logic next_oscEn;
  logic srcGate;
  logic next_srcGate;
  logic [CPUDIV_W-1:0] cpuDiv;
  logic [CPUDIV_W-1:0] next_cpuDiv;
  logic [USBDIV_W-1:0] usbDiv;
  logic [USBDIV_W-1:0] next_usbDiv;
  logic [NPERIPH-1:0] pconp;
  logic [NPERIPH-1:0] next_pconp;
  logic [2*NPERIPH-1:0] pclkSel;
  logic [2*NPERIPH-1:0] next_pclkSel;

  assign addrPhase = hsel && htrans[1] && hready;

  always_comb begin
    rdVal = 32'h00000000;
    case (haddr[7:0])
      cpwc_pkg::OFS_CTRL: begin
        rdVal[cpwc_pkg::CTRL_SRC_LSB +: 2] = srcReq;
        rdVal[cpwc_pkg::CTRL_PLLEN] = pllCfg.enable;
        rdVal[cpwc_pkg::CTRL_PLLCON] = conReq;
        rdVal[cpwc_pkg::CTRL_OSCEN] = oscEn;
      end
      cpwc_pkg::OFS_PLLCFG: begin
        rdVal[cpwc_pkg::PLLCFG_N_LSB +: cpwc_pkg::PREDIV_W] = pllCfg.preDiv;
        rdVal[cpwc_pkg::PLLCFG_M_LSB +: cpwc_pkg::MUL_W] = pllCfg.mul;
      end
      cpwc_pkg::OFS_CPUDIV: rdVal[CPUDIV_W-1:0] = cpuDiv;
      cpwc_pkg::OFS_USBDIV: rdVal[USBDIV_W-1:0] = usbDiv;
      cpwc_pkg::OFS_PCONP: rdVal[NPERIPH-1:0] = pconp;
      cpwc_pkg::OFS_PCLKSEL: rdVal[2*NPERIPH-1:0] = pclkSel;
      cpwc_pkg::OFS_STATUS: begin
        rdVal[cpwc_pkg::ST_LOCK] = lockS;
        rdVal[cpwc_pkg::ST_CONN] = pllCfg.connect;
        rdVal[cpwc_pkg::ST_SRC_LSB +: 2] = srcSel;
        rdVal[cpwc_pkg::ST_OSCRDY] = mainS;
        rdVal[cpwc_pkg::ST_FLASHRDY] = flashReady;
        rdVal[cpwc_pkg::ST_HALT] = cpuHalt;
        rdVal[cpwc_pkg::ST_STATE_LSB +: 3] = state;
      end
      default: rdVal = 32'h00000000;
    endcase
    next_wrQ = addrPhase && hwrite;
    next_addrQ = haddr[7:0];
    next_hrdata = (addrPhase && !hwrite) ? rdVal : 32'h00000000;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrQ <= 1'b0;
      addrQ <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrQ <= next_wrQ;
      addrQ <= next_addrQ;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Configuration registers
  logic enterLow;
  logic wakePd;
  logic tgtReady;
  assign enterLow = state == cpwc_pkg::CPWC_ST_RUN && (modeCmd == cpwc_pkg::CPWC_MODE_SLEEP ||
                    modeCmd == cpwc_pkg::CPWC_MODE_PDOWN || modeCmd == cpwc_pkg::CPWC_MODE_DPDOWN);
  assign wakePd = state == cpwc_pkg::CPWC_ST_IRCUP && ircS;

  always_comb begin
    next_srcReq = srcReq;
    next_srcSel = srcSel;
    next_srcGate = srcGate;
    next_pllCfg = pllCfg;
    next_conReq = conReq;
    next_oscEn = oscEn;
    next_cpuDiv = cpuDiv;
    next_usbDiv = usbDiv;
    next_pconp = pconp;
    next_pclkSel = pclkSel;
    next_modeCmd = cpwc_pkg::CPWC_MODE_NONE;
    tgtReady = 1'b0;
    unique case (srcReq)
      cpwc_pkg::CPWC_SRC_IRC: tgtReady = ircS;
      cpwc_pkg::CPWC_SRC_MAIN: tgtReady = mainS;
      cpwc_pkg::CPWC_SRC_RTC: tgtReady = rtcS;
    endcase
    if (wrQ) begin
      case (addrQ)
        cpwc_pkg::OFS_CTRL: begin
          if (hwdata[cpwc_pkg::CTRL_SRC_LSB +: 2] != 2'h3) begin
            next_srcReq = cpwc_pkg::cpwc_src_t'(hwdata[cpwc_pkg::CTRL_SRC_LSB +: 2]);
          end
          next_pllCfg.enable = hwdata[cpwc_pkg::CTRL_PLLEN];
          next_conReq = hwdata[cpwc_pkg::CTRL_PLLCON];
          next_oscEn = hwdata[cpwc_pkg::CTRL_OSCEN];
        end
        cpwc_pkg::OFS_PLLCFG: begin
          next_pllCfg.preDiv = hwdata[cpwc_pkg::PLLCFG_N_LSB +: cpwc_pkg::PREDIV_W];
          next_pllCfg.mul = hwdata[cpwc_pkg::PLLCFG_M_LSB +: cpwc_pkg::MUL_W];
        end
        cpwc_pkg::OFS_CPUDIV: next_cpuDiv = hwdata[CPUDIV_W-1:0];
        cpwc_pkg::OFS_USBDIV: next_usbDiv = hwdata[USBDIV_W-1:0];
        cpwc_pkg::OFS_PCONP: next_pconp = hwdata[NPERIPH-1:0];
        cpwc_pkg::OFS_PCLKSEL: next_pclkSel = hwdata[2*NPERIPH-1:0];
        cpwc_pkg::OFS_PCON: begin
          if (hwdata[2:0] <= 3'h4) begin
            next_modeCmd = cpwc_pkg::cpwc_mode_t'(hwdata[2:0]);
          end
        end
        default: ;
      endcase
    end
    if (enterLow) begin
      next_pllCfg.enable = 1'b0;
      next_conReq = 1'b0;
      next_cpuDiv = '0;
      next_usbDiv = '0;
    end
    if (wakePd) begin
      next_srcReq = cpwc_pkg::CPWC_SRC_IRC;
      next_srcSel = cpwc_pkg::CPWC_SRC_IRC;
      next_srcGate = 1'b1;
    end else if (srcReq != srcSel && tgtReady) begin
      // Stop the clock one cycle before and after moving the mux
      if (srcGate) begin
        next_srcGate = 1'b0;
      end else begin
        next_srcSel = srcReq;
      end
    end else begin
      next_srcGate = 1'b1;
    end
    next_pllCfg.connect = next_pllCfg.enable && next_conReq && lockS;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      srcReq <= cpwc_pkg::CPWC_SRC_IRC;
      srcSel <= cpwc_pkg::CPWC_SRC_IRC;
      srcGate <= 1'b1;
      pllCfg <= '0;
      conReq <= 1'b0;
      oscEn <= 1'b0;
      cpuDiv <= CPUDIV_W'(cpwc_pkg::CPUDIV_RST);
      usbDiv <= USBDIV_W'(cpwc_pkg::USBDIV_RST);
      pconp <= NPERIPH'(cpwc_pkg::PCONP_RST);
      pclkSel <= (2*NPERIPH)'(cpwc_pkg::PCLKSEL_RST);
      modeCmd <= cpwc_pkg::CPWC_MODE_NONE;
    end else begin
      srcReq <= next_srcReq;
      srcSel <= next_srcSel;
      srcGate <= next_srcGate;
      pllCfg <= next_pllCfg;
      conReq <= next_conReq;
      oscEn <= next_oscEn;
      cpuDiv <= next_cpuDiv;
      usbDiv <= next_usbDiv;
      pconp <= next_pconp;
      pclkSel <= next_pclkSel;
      modeCmd <= next_modeCmd;
    end
  end

  // Power-mode sequencer and wake-up timers
  logic [cpwc_pkg::WCNT_W-1:0] wakeCnt;
  logic [cpwc_pkg::WCNT_W-1:0] next_wakeCnt;
  logic [cpwc_pkg::FCNT_W-1:0] flashCnt;
  logic [cpwc_pkg::FCNT_W-1:0] next_flashCnt;
  logic next_cpuHalt;
  logic next_flashReady;
  logic next_ircEnable;
  logic next_mainOscEnable;
  logic flashOff;

  always_comb begin
    next_state = state;
    next_wakeCnt = wakeCnt;
    unique case (state)
      cpwc_pkg::CPWC_ST_RUN: begin
        unique case (modeCmd)
          cpwc_pkg::CPWC_MODE_IDLE: next_state = cpwc_pkg::CPWC_ST_IDLE;
          cpwc_pkg::CPWC_MODE_SLEEP: next_state = cpwc_pkg::CPWC_ST_SLEEP;
          cpwc_pkg::CPWC_MODE_PDOWN: next_state = cpwc_pkg::CPWC_ST_PDOWN;
          cpwc_pkg::CPWC_MODE_DPDOWN: next_state = cpwc_pkg::CPWC_ST_DPDOWN;
          cpwc_pkg::CPWC_MODE_NONE: ;
        endcase
      end
      cpwc_pkg::CPWC_ST_IDLE: if (wakeS) next_state = cpwc_pkg::CPWC_ST_RUN;
      cpwc_pkg::CPWC_ST_SLEEP: begin
        if (wakeS) begin
          next_state = cpwc_pkg::CPWC_ST_WAKE;
          next_wakeCnt = (srcSel == cpwc_pkg::CPWC_SRC_IRC) ? cpwc_pkg::WAKE_IRC_LOAD
                                                             : cpwc_pkg::WAKE_OSC_LOAD;
        end
      end
      cpwc_pkg::CPWC_ST_PDOWN: if (wakeS) next_state = cpwc_pkg::CPWC_ST_IRCUP;
      cpwc_pkg::CPWC_ST_DPDOWN: ;
      cpwc_pkg::CPWC_ST_IRCUP: begin
        if (ircS) begin
          next_state = cpwc_pkg::CPWC_ST_WAKE;
          next_wakeCnt = cpwc_pkg::WAKE_IRC_LOAD;
        end
      end
      cpwc_pkg::CPWC_ST_WAKE: begin
        if (wakeCnt != '0) begin
          next_wakeCnt = wakeCnt - cpwc_pkg::WCNT_W'(1);
        end else if (srcSel != cpwc_pkg::CPWC_SRC_MAIN || mainS) begin
          next_state = cpwc_pkg::CPWC_ST_RUN;
        end
      end
    endcase
    flashOff = next_state == cpwc_pkg::CPWC_ST_PDOWN || next_state == cpwc_pkg::CPWC_ST_DPDOWN ||
               next_state == cpwc_pkg::CPWC_ST_IRCUP;
    if (flashOff) begin
      next_flashCnt = cpwc_pkg::FLASH_LOAD;
    end else if (flashCnt != '0) begin
      next_flashCnt = flashCnt - cpwc_pkg::FCNT_W'(1);
    end else begin
      next_flashCnt = flashCnt;
    end
    next_flashReady = !flashOff && next_flashCnt == '0;
    next_cpuHalt = next_state != cpwc_pkg::CPWC_ST_RUN;
    next_ircEnable = !flashOff || next_state == cpwc_pkg::CPWC_ST_IRCUP;
    next_mainOscEnable = next_oscEn && (next_state == cpwc_pkg::CPWC_ST_RUN ||
                                        next_state == cpwc_pkg::CPWC_ST_IDLE ||
                                        next_state == cpwc_pkg::CPWC_ST_WAKE);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= cpwc_pkg::CPWC_ST_WAKE;
      wakeCnt <= cpwc_pkg::WAKE_IRC_LOAD;
      flashCnt <= cpwc_pkg::FLASH_LOAD;
      cpuHalt <= 1'b1;
      flashReady <= 1'b0;
      ircEnable <= 1'b1;
      mainOscEnable <= 1'b0;
    end else begin
      state <= next_state;
      wakeCnt <= next_wakeCnt;
      flashCnt <= next_flashCnt;
      cpuHalt <= next_cpuHalt;
      flashReady <= next_flashReady;
      ircEnable <= next_ircEnable;
      mainOscEnable <= next_mainOscEnable;
    end
  end

  // Clock dividers
  logic periphRun;
  assign periphRun = srcGate && (state == cpwc_pkg::CPWC_ST_RUN || state == cpwc_pkg::CPWC_ST_IDLE);

  cpwc_divider #(.W(CPUDIV_W)) u_cpuDiv (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(srcGate && state == cpwc_pkg::CPWC_ST_RUN),
    .div(cpuDiv),
    .tick(cpuClkEn)
  );

  cpwc_divider #(.W(USBDIV_W)) u_usbDiv (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(periphRun && pllCfg.enable && lockS),
    .div(usbDiv),
    .tick(usbClkEn)
  );

  for (genvar i = 0; i < NPERIPH; i++) begin : g_periph
    cpwc_divider #(.W(3)) u_pDiv (
      .mclk(mclk),
      .reset_n(reset_n),
      .run(periphRun && pconp[i]),
      .div(pclkDiv(pclkSel[2*i +: 2])),
      .tick(periphClkEn[i])
    );
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_reset_irc;
    $rose(reset_n) |-> srcSel == cpwc_pkg::CPWC_SRC_IRC && cpuHalt;
  endproperty
  a_reset_irc: assert property (p_reset_irc) else $error("reset did not select RC source");

  property p_src_follows_req;
    srcSel != $past(srcSel) |-> srcSel == $past(srcReq) && !$past(srcGate);
  endproperty
  a_src_follows_req: assert property (p_src_follows_req) else $error("source changed unrequested");

  property p_connect_locked;
    $rose(pllCfg.connect) |-> $past(lockS) && pllCfg.enable;
  endproperty
  a_connect_locked: assert property (p_connect_locked) else $error("PLL connected without lock");

  property p_sleep_clear;
    enterLow |=> !pllCfg.enable && !pllCfg.connect && cpuDiv == '0 && usbDiv == '0;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("low-power entry left PLL on");

  property p_sleep_wake_irc;
    state == cpwc_pkg::CPWC_ST_SLEEP && wakeS && srcSel == cpwc_pkg::CPWC_SRC_IRC |->
      cpuHalt [*5] ##1 !cpuHalt;
  endproperty
  a_sleep_wake_irc: assert property (p_sleep_wake_irc) else $error("sleep wake not 4 cycles");

  property p_pd_wake_irc;
    wakePd |=> srcSel == cpwc_pkg::CPWC_SRC_IRC && srcReq == cpwc_pkg::CPWC_SRC_IRC;
  endproperty
  a_pd_wake_irc: assert property (p_pd_wake_irc) else $error("power-down wake not on RC");

  property p_flash_hold;
    wakePd |=> !flashReady [*8];
  endproperty
  a_flash_hold: assert property (p_flash_hold) else $error("flash ready too early");

  property p_osc_block;
    state == cpwc_pkg::CPWC_ST_WAKE && srcSel == cpwc_pkg::CPWC_SRC_MAIN && !mainS |=> cpuHalt;
  endproperty
  a_osc_block: assert property (p_osc_block) else $error("ran before oscillator ready");

  property p_idle_entry;
    state == cpwc_pkg::CPWC_ST_RUN && modeCmd == cpwc_pkg::CPWC_MODE_IDLE |=>
      state == cpwc_pkg::CPWC_ST_IDLE && cpuHalt;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_pd_pll_off;
    state == cpwc_pkg::CPWC_ST_PDOWN |-> !pllCfg.enable && !pllCfg.connect && !flashReady;
  endproperty
  a_pd_pll_off: assert property (p_pd_pll_off) else $error("PLL on in power-down");

  c_pll_connect: cover property ($rose(pllCfg.connect));
  c_sleep_wake: cover property (state == cpwc_pkg::CPWC_ST_SLEEP ##1 state == cpwc_pkg::CPWC_ST_WAKE);
  c_pd_flash: cover property (state == cpwc_pkg::CPWC_ST_IRCUP ##[1:1000] $rose(flashReady));

endmodule : cpwc_top

// *** tb/cpwc_osc_model.sv ***
`timescale 1ns/1ps
module cpwc_osc_model #(
  parameter int MAIN_DLY = 20,
  parameter int IRC_DLY = 10,
  parameter int LOCK_DLY = 30
) (
  input wire logic mclk,
  input wire logic ircEnable,
  input wire logic mainOscEnable,
  input wire logic pllEnable,
  output logic mainOscReady,
  output logic ircReady,
  output logic rtcOscReady,
  output logic pllLock
);
  int mainCnt = 0;
  int ircCnt = 0;
  int lockCnt = 0;
  initial {mainOscReady, ircReady, pllLock} = 3'h0;
  assign rtcOscReady = 1'b1;
  // Ready and lock drop at once when the source is switched off
  always @(posedge mclk) begin
    mainCnt <= mainOscEnable ? mainCnt + 1 : 0;
    ircCnt <= ircEnable ? ircCnt + 1 : 0;
    lockCnt <= pllEnable ? lockCnt + 1 : 0;
    mainOscReady <= mainOscEnable && mainCnt >= MAIN_DLY;
    ircReady <= ircEnable && ircCnt >= IRC_DLY;
    pllLock <= pllEnable && lockCnt >= LOCK_DLY;
  end
endmodule : cpwc_osc_model

// *** tb/cpwc_top_tb_top.sv ***
`timescale 1ns/1ps
module cpwc_top_tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic wakeEvent = 1'b0;
  logic hreadyout, hresp, mainOscReady, ircReady, rtcOscReady, pllLock;
  logic ircEnable, mainOscEnable, cpuClkEn, usbClkEn, cpuHalt, flashReady;
  logic [31:0] hrdata;
  logic [7:0] periphClkEn;
  cpwc_pkg::cpwc_src_t srcSel;
  cpwc_pkg::cpwc_pll_cfg_t pllCfg;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] mdl [int];
  logic [31:0] q;
  int d;
  always #50 mclk = ~mclk;
  cpwc_top dut (.mclk(mclk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mainOscReady(mainOscReady), .ircReady(ircReady),
    .rtcOscReady(rtcOscReady), .pllLock(pllLock), .wakeEvent(wakeEvent), .srcSel(srcSel),
    .ircEnable(ircEnable), .mainOscEnable(mainOscEnable), .pllCfg(pllCfg), .cpuClkEn(cpuClkEn),
    .usbClkEn(usbClkEn), .periphClkEn(periphClkEn), .cpuHalt(cpuHalt), .flashReady(flashReady));
  cpwc_osc_model osc (.mclk(mclk), .ircEnable(ircEnable), .mainOscEnable(mainOscEnable),
    .pllEnable(pllCfg.enable), .mainOscReady(mainOscReady), .ircReady(ircReady),
    .rtcOscReady(rtcOscReady), .pllLock(pllLock));

  task automatic wrap_up;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= dat;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    q = hrdata;
    if (k >= 50) begin
      chk(k, 0);
      wrap_up();
    end
  endtask : bus

  // Model keeps the readable image; a zero mask marks a place that reads 0
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [31:0] m);
    mdl[a] = dat & m;
    bus(1'b1, a, dat);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    chk(q, mdl.exists(a) ? mdl[a] : 32'h0);
  endtask : rd

  task automatic wait_sig(input int w, input logic v, input int lo, input int hi);
    int k;
    logic s;
    for (k = 1; k <= hi; k++) begin
      @(posedge mclk);
      s = w == 0 ? cpuHalt : w == 1 ? flashReady : w == 2 ? pllCfg.connect : srcSel === cpwc_pkg::CPWC_SRC_MAIN;
      if (s === v)
        break;
    end
    chk(k >= lo && k <= hi, 1);
    if (k > hi)
      wrap_up();
  endtask : wait_sig

  // Software reads the status word until the given bit is set
  task automatic poll(input int b);
    int k;
    for (k = 0; k < 100; k++) begin
      bus(1'b0, 8'h1C, 32'h0);
      if (q[b] === 1'b1)
        break;
    end
    chk(k < 100, 1);
    if (k >= 100)
      wrap_up();
  endtask : poll

  // A missing tick yields 401
  task automatic tick_period(input int w, input int exp);
    int k;
    int t0;
    logic s;
    t0 = -1;
    // Skip a tick launched under the old setting
    @(posedge mclk);
    for (k = 0; k < 400; k++) begin
      @(posedge mclk);
      s = w == 0 ? cpuClkEn : w == 1 ? usbClkEn : periphClkEn[w-2];
      if (s === 1'b1) begin
        if (t0 >= 0)
          break;
        t0 = k;
      end
    end
    chk(k - t0, exp);
  endtask : tick_period

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    mdl.delete();
  endtask : do_reset

  initial begin
    void'($urandom(98));
    @(posedge mclk);
    do_reset();
    chk(srcSel, cpwc_pkg::CPWC_SRC_IRC);
    chk(pllCfg, 32'h0);
    wait_sig(0, 1'b0, 4, 8);
    wait_sig(1, 1'b1, 990, 1010);
    rd(8'h08);
    rd(8'h14);
    wr(8'h40, 32'hFFFFFFFF, 32'h0);
    rd(8'h40);
    chk(hresp, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = i == 0 ? 0 : i == 1 ? 32'h7FFFFF : $urandom & 32'h7FFFFF;
      wr(8'h04, d, 32'h7FFFFF);
      rd(8'h04);
      chk({pllCfg.mul, pllCfg.preDiv}, d);
    end
    d = 1 + $urandom % 5;
    wr(8'h08, d, 32'hFF);
    tick_period(0, d + 1);
    wr(8'h10, 32'hFE, 32'hFF);
    rd(8'h10);
    tick_period(2, 401);
    d = $urandom % 4;
    wr(8'h14, d << 2, 32'hFFFF);
    tick_period(3, 1 << d);
    // N of 1 and M of 100 set before the PLL is switched on
    wr(8'h04, 32'h6300, 32'h7FFFFF);
    wr(8'h00, 32'h14, 32'h0);
    poll(4);
    wr(8'h00, 32'h15, 32'h0);
    wait_sig(3, 1'b1, 1, 80);
    poll(0);
    wr(8'h00, 32'h1D, 32'h0);
    wait_sig(2, 1'b1, 1, 2);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q[4:0], 5'h17);
    d = $urandom % 8;
    wr(8'h0C, d, 32'hF);
    tick_period(1, d + 1);
    wr(8'h18, 32'h2, 32'h0);
    mdl[8'h08] = 32'h0;
    mdl[8'h0C] = 32'h0;
    repeat (3) @(posedge mclk);
    chk({cpuHalt, pllCfg.enable, pllCfg.connect, mainOscEnable}, 4'h8);
    rd(8'h08);
    rd(8'h0C);
    wakeEvent <= 1'b1;
    wait_sig(0, 1'b0, 4096, 4200);
    wakeEvent <= 1'b0;
    wr(8'h00, 32'h14, 32'h0);
    repeat (4) @(posedge mclk);
    chk(pllCfg.enable, 1'b1);
    wr(8'h18, 32'h3, 32'h0);
    repeat (4) @(posedge mclk);
    chk({pllCfg.enable, ircEnable}, 2'h0);
    wakeEvent <= 1'b1;
    wait_sig(0, 1'b0, 5, 60);
    chk(srcSel, cpwc_pkg::CPWC_SRC_IRC);
    wait_sig(1, 1'b1, 900, 1010);
    wakeEvent <= 1'b0;
    wr(8'h18, 32'h2, 32'h0);
    repeat (3) @(posedge mclk);
    wakeEvent <= 1'b1;
    wait_sig(0, 1'b0, 7, 9);
    wakeEvent <= 1'b0;
    wr(8'h18, 32'h1, 32'h0);
    repeat (3) @(posedge mclk);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q[10:8], 3'h1);
    do_reset();
    wait_sig(0, 1'b0, 4, 8);
    wr(8'h18, 32'h4, 32'h0);
    repeat (3) @(posedge mclk);
    bus(1'b0, 8'h1C, 32'h0);
    chk({q[10:8], q[6]}, 4'h9);
    do_reset();
    chk(srcSel, cpwc_pkg::CPWC_SRC_IRC);
    wrap_up();
  end
endmodule : cpwc_top_tb_top
